// >>> psf_pkg.sv
// constants for the parallel-serial fifo and its serial input link stage
`default_nettype none

package psf_pkg;
  localparam int WORD_W = 9;
  localparam int DEPTH_DEF = 2048;
  localparam int NEAR_DIV = 8;
  localparam int HALF_DIV = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CHAIN_PULSE_NS = 50;
  // least time, so round up; never under one cycle
  localparam int CHAIN_PULSE_CYC_RAW = (CHAIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAIN_PULSE_CYC = (CHAIN_PULSE_CYC_RAW < 1) ? 1 : CHAIN_PULSE_CYC_RAW;
  localparam int PCNT_W = 4;
  // bit positions inside the pin synchroniser vector
  localparam int P_WR = 0;
  localparam int P_RD = 1;
  localparam int P_OE = 2;
  localparam int P_RSTN = 3;
  localparam int P_FLRT = 4;
  localparam int P_XI = 5;
  localparam int P_IMODE = 6;
  localparam int P_OMODE = 7;
  localparam int P_TOG = 8;
  localparam int P_DATA = 9;
  localparam int SYNC_W = P_DATA + WORD_W;

  typedef enum logic [2:0] {
    PSF_CH_IDLE = 3'h1,
    PSF_CH_PULSE = 3'h2,
    PSF_CH_GAP = 3'h4
  } psf_chain_e;
endpackage

// ***************************************
// serial input stage on the link clock
// ***************************************
module psf_ser_in (
  input wire logic serial_in_clock,
  input wire logic rst,
  input wire logic serial_in,
  input wire logic serial_in_expand,
  input wire logic write_n,
  output logic [psf_pkg::WORD_W-1:0] input_width_tap,
  output logic [psf_pkg::WORD_W-1:0] word_hold,
  output logic commit_tog
);
  import psf_pkg::*;

  logic [WORD_W-1:0] taps_q, taps_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic [WORD_W-1:0] hold_q, hold_d;
  logic tog_q, tog_d;

  always_comb begin
    taps_d = taps_q;
    word_d = word_q;
    hold_d = hold_q;
    tog_d = tog_q;
    // write strobe is our own tap looped back, so it is already in this domain
    if (write_n) begin
      hold_d = word_q;
      tog_d = ~tog_q;
      word_d = '0;
      taps_d = '0;
      if (serial_in_expand) begin
        word_d[0] = serial_in;
        taps_d[0] = 1'b1;
      end
    end else if (serial_in_expand && !taps_q[WORD_W-1]) begin
      // thermometer delay line: next free bit stores the incoming bit, lsb first
      for (int k = 0; k < WORD_W; k++) begin
        if (!taps_q[k] && (k == 0 || taps_q[(k == 0) ? 0 : k-1])) begin
          word_d[k] = serial_in;
        end
      end
      taps_d = {taps_q[WORD_W-2:0], 1'b1};
    end
  end

  always_ff @(posedge serial_in_clock or posedge rst) begin
    if (rst) begin
      taps_q <= '0;
      word_q <= '0;
      hold_q <= '0;
      tog_q <= 1'b0;
    end else begin
      taps_q <= taps_d;
      word_q <= word_d;
      hold_q <= hold_d;
      tog_q <= tog_d;
    end
  end

  assign input_width_tap = taps_q;
  assign word_hold = hold_q;
  assign commit_tog = tog_q;
endmodule

`default_nettype wire

// >>> psf_fifo.sv
// parallel-serial fifo core: storage, pointers, flags, depth chain and parallel ports
// ***************************************
// ***************************************
`default_nettype none

module psf_fifo #(
  parameter int DEPTH = psf_pkg::DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic out_enable_n,
  input wire logic reset_n,
  input wire logic first_load_replay_n,
  input wire logic chain_in_n,
  input wire logic input_mode_select,
  input wire logic output_mode_select,
  input wire logic [psf_pkg::WORD_W-1:0] parallel_in_bus,
  input wire logic serial_in_clock,
  input wire logic serial_in,
  input wire logic serial_in_expand,
  output logic [psf_pkg::WORD_W-1:0] input_width_tap,
  output logic input_tap_en,
  output logic [psf_pkg::WORD_W-1:0] parallel_out_bus,
  output logic parallel_out_en,
  output logic full_n,
  output logic empty_n,
  output logic near_empty_full_n,
  output logic half_or_chain_out
);
  import psf_pkg::*;

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W = ADDR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] NEAR_LO = CNT_W'(DEPTH / NEAR_DIV);
  localparam logic [CNT_W-1:0] NEAR_HI = CNT_W'(DEPTH - DEPTH / NEAR_DIV);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(DEPTH / HALF_DIV);
  localparam logic [ADDR_W-1:0] LAST_LOC = ADDR_W'(DEPTH - 1);
  localparam logic [PCNT_W-1:0] PULSE_END = PCNT_W'(CHAIN_PULSE_CYC - 1);
  // pins idle: strobes high so no false edge follows reset; parallel input keeps taps off
  localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'((1 << P_WR) | (1 << P_RD) | (1 << P_OE) | (1 << P_RSTN)
                                                     | (1 << P_FLRT) | (1 << P_IMODE));

  // ***************************************
  // serial input link stage
  // ***************************************
  logic [WORD_W-1:0] ser_word;
  logic ser_tog;

  psf_ser_in u_ser_in (
    .serial_in_clock(serial_in_clock),
    .rst(rst),
    .serial_in(serial_in),
    .serial_in_expand(serial_in_expand),
    .write_n(write_n),
    .input_width_tap(input_width_tap),
    .word_hold(ser_word),
    .commit_tog(ser_tog)
  );

  // ***************************************
  // pin synchronisers
  // ***************************************
  logic [SYNC_W-1:0] pins, s1_q, s2_q;
  assign pins = {parallel_in_bus, ser_tog, output_mode_select, input_mode_select, chain_in_n,
                 first_load_replay_n, reset_n, out_enable_n, read_n, write_n};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  // ***************************************
  // storage, pointers and flags
  // ***************************************
  logic [WORD_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [WORD_W-1:0] out_q, out_d;
  logic oen_q, oen_d, tap_en_q, tap_en_d;
  logic full_n_q, full_n_d, empty_n_q, empty_n_d, near_n_q, near_n_d, hoc_q, hoc_d;
  logic wr_prev_q, rd_prev_q, tog_prev_q, xi_prev_q;
  logic depth_q, depth_d, wr_tok_q, wr_tok_d, rd_tok_q, rd_tok_d, tok_next_q, tok_next_d;
  logic [1:0] pend_q, pend_d;
  logic [PCNT_W-1:0] pcnt_q, pcnt_d;
  psf_chain_e ch_q, ch_d;
  logic wr_ev, rd_ev, do_wr, do_rd, replay, wr_wrap, rd_wrap;
  logic [WORD_W-1:0] wr_data;

  always_comb begin
    // serial commits cross by toggle; the held word is stable long before the toggle lands
    wr_ev = s2_q[P_IMODE] ? (s2_q[P_WR] && !wr_prev_q) : (s2_q[P_TOG] != tog_prev_q);
    wr_data = s2_q[P_IMODE] ? s2_q[P_DATA +: WORD_W] : ser_word;
    rd_ev = s2_q[P_OMODE] && !s2_q[P_RD] && rd_prev_q;
    do_wr = wr_ev && (cnt_q != FULL_CNT) && wr_tok_q;
    do_rd = rd_ev && (cnt_q != '0) && rd_tok_q;
    replay = !depth_q && !s2_q[P_FLRT];
    wr_wrap = do_wr && depth_q && (wr_ptr_q == LAST_LOC);
    rd_wrap = do_rd && depth_q && (rd_ptr_q == LAST_LOC);
    wr_ptr_d = do_wr ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = do_rd ? rd_ptr_q + 1'b1 : rd_ptr_q;
    cnt_d = cnt_q + CNT_W'(do_wr) - CNT_W'(do_rd);
    out_d = do_rd ? mem[rd_ptr_q] : out_q;
    // output mode low means the serial side owns the word, so the bus stays off
    oen_d = s2_q[P_OMODE] && !s2_q[P_RD] && !s2_q[P_OE];
    tap_en_d = !s2_q[P_IMODE];
    depth_d = depth_q;
    wr_tok_d = wr_tok_q && !wr_wrap;
    rd_tok_d = rd_tok_q && !rd_wrap;
    tok_next_d = tok_next_q;
    pend_d = pend_q + 2'(wr_wrap) + 2'(rd_wrap);
    pcnt_d = pcnt_q;
    ch_d = ch_q;
    // tokens arrive in the order they leave: write first, then read
    if (depth_q && !s2_q[P_XI] && xi_prev_q) begin
      if (!tok_next_q) begin
        wr_tok_d = 1'b1;
      end else begin
        rd_tok_d = 1'b1;
      end
      tok_next_d = ~tok_next_q;
    end
    unique case (ch_q)
      PSF_CH_IDLE: begin
        if (pend_q != '0) begin
          ch_d = PSF_CH_PULSE;
          pcnt_d = '0;
          pend_d = pend_d - 2'h1;
        end
      end
      PSF_CH_PULSE: begin
        pcnt_d = pcnt_q + 1'b1;
        if (pcnt_q == PULSE_END) begin
          ch_d = PSF_CH_GAP;
          pcnt_d = '0;
        end
      end
      PSF_CH_GAP: begin
        pcnt_d = pcnt_q + 1'b1;
        if (pcnt_q == PULSE_END) begin
          ch_d = PSF_CH_IDLE;
        end
      end
    endcase
    if (replay) begin
      rd_ptr_d = '0;
      cnt_d = CNT_W'(wr_ptr_d);
    end
    if (!s2_q[P_RSTN]) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      cnt_d = '0;
      oen_d = 1'b0;
      depth_d = s2_q[P_XI];
      wr_tok_d = !s2_q[P_XI] || !s2_q[P_FLRT];
      rd_tok_d = !s2_q[P_XI] || !s2_q[P_FLRT];
      tok_next_d = 1'b0;
      pend_d = '0;
      pcnt_d = '0;
      ch_d = PSF_CH_IDLE;
    end
    full_n_d = (cnt_d != FULL_CNT);
    empty_n_d = (cnt_d != '0);
    near_n_d = !((cnt_d < NEAR_LO) || (cnt_d > NEAR_HI));
    // the shared pin is the half-full flag alone, or the chain pulse in depth mode
    hoc_d = depth_d ? (ch_d != PSF_CH_PULSE) : !(cnt_d > HALF_CNT);
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      oen_q <= 1'b0;
      tap_en_q <= 1'b0;
      full_n_q <= 1'b1;
      empty_n_q <= 1'b0;
      near_n_q <= 1'b0;
      hoc_q <= 1'b1;
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
      tog_prev_q <= 1'b0;
      xi_prev_q <= 1'b0;
      depth_q <= 1'b0;
      wr_tok_q <= 1'b1;
      rd_tok_q <= 1'b1;
      tok_next_q <= 1'b0;
      pend_q <= '0;
      pcnt_q <= '0;
      ch_q <= PSF_CH_IDLE;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      oen_q <= oen_d;
      tap_en_q <= tap_en_d;
      full_n_q <= full_n_d;
      empty_n_q <= empty_n_d;
      near_n_q <= near_n_d;
      hoc_q <= hoc_d;
      wr_prev_q <= s2_q[P_WR];
      rd_prev_q <= s2_q[P_RD];
      tog_prev_q <= s2_q[P_TOG];
      xi_prev_q <= s2_q[P_XI];
      depth_q <= depth_d;
      wr_tok_q <= wr_tok_d;
      rd_tok_q <= rd_tok_d;
      tok_next_q <= tok_next_d;
      pend_q <= pend_d;
      pcnt_q <= pcnt_d;
      ch_q <= ch_d;
    end
  end

  assign input_tap_en = tap_en_q;
  assign parallel_out_bus = out_q;
  assign parallel_out_en = oen_q;
  assign full_n = full_n_q;
  assign empty_n = empty_n_q;
  assign near_empty_full_n = near_n_q;
  assign half_or_chain_out = hoc_q;
endmodule

`default_nettype wire

// >>> psf_fifo_checker.sv
// assertion checker on the parallel-serial fifo ports
`default_nettype none
module psf_fifo_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic out_enable_n,
  input wire logic reset_n,
  input wire logic first_load_replay_n,
  input wire logic input_mode_select,
  input wire logic output_mode_select,
  input wire logic input_tap_en,
  input wire logic parallel_out_en,
  input wire logic full_n,
  input wire logic empty_n,
  input wire logic near_empty_full_n,
  input wire logic half_or_chain_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ***************************************
  // flag and bus drive relations
  // ***************************************
  AST_RST_FLAGS: assert property ($fell(rst) |-> full_n && !empty_n && !near_empty_full_n && half_or_chain_out)
    else $error("flags wrong after reset");
  AST_PIN_RST: assert property ((!reset_n)[*4] |=> full_n && !empty_n && half_or_chain_out)
    else $error("reset pin did not clear flags");
  AST_OE_OFF: assert property (out_enable_n[*4] |-> !parallel_out_en)
    else $error("bus driven with output enable high");
  AST_RD_OFF: assert property (read_n[*4] |-> !parallel_out_en)
    else $error("bus driven with read high");
  AST_RD_ON: assert property ((!read_n && !out_enable_n && output_mode_select && reset_n)[*5] |-> parallel_out_en)
    else $error("bus not driven during read");
  AST_MODE_OFF: assert property (!output_mode_select |-> !parallel_out_en)
    else $error("bus driven outside parallel mode");
  // replay may legally raise the count, so it is excluded
  AST_EMPTY_HOLD: assert property ((!empty_n && write_n && first_load_replay_n)[*5] |=> !empty_n)
    else $error("empty left without a write");
  AST_FULL_HOLD: assert property ((!full_n && read_n && first_load_replay_n && reset_n)[*5] |=> !full_n)
    else $error("full left without a read");
  AST_HALF_EMPTY: assert property (!empty_n |-> half_or_chain_out && !near_empty_full_n)
    else $error("half or near flag wrong when empty");
  AST_FULL_FLAGS: assert property (!full_n |-> !half_or_chain_out && !near_empty_full_n)
    else $error("half or near flag wrong when full");
  AST_TAP_OFF: assert property (input_mode_select[*4] |-> !input_tap_en)
    else $error("taps driven in parallel input mode");
endmodule
bind psf_fifo psf_fifo_checker chk (.*);
`default_nettype wire

// >>> psf_ser_src.sv
// serial link source model for the fifo serial input
`default_nettype none
module psf_ser_src (
  output logic sclk,
  output logic sdat,
  output logic sexp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdat = 1'b0;
    sexp = 1'b1;
  end
  // link clock runs only inside a frame; data lsb first
  task automatic send(input logic [7:0] w, input int n);
    for (int b = 0; b < n; b++) begin
      sdat = w[b];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    sdat = ~sdat;
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the parallel-serial fifo
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import psf_pkg::*;
  localparam int D = 2048;
  logic clk = 0, rst = 1, wr_n = 1, rd_n = 1, oe_n = 0, rs_n = 1, fl_n = 1, im = 1, om = 1, xi_n = 0;
  bit wr_ok = 1;
  logic [WORD_W-1:0] din = 9'h000;
  logic sclk, sdat, sexp;
  wire logic [WORD_W-1:0] tap, bus;
  wire logic tap_en, oen, full_n, empty_n, near_n, half_n;
  wire logic write_n = im ? wr_n : tap[7];
  int n_mismatch = 0, checks = 0, cnt = 0;
  logic [WORD_W-1:0] q[$];
  logic [WORD_W-1:0] keep[5];
  always #5 clk = ~clk;
  psf_ser_src src (.sclk(sclk), .sdat(sdat), .sexp(sexp));
  psf_fifo #(.DEPTH(D)) dut (.clk(clk), .rst(rst), .write_n(write_n), .read_n(rd_n), .out_enable_n(oe_n),
    .reset_n(rs_n), .first_load_replay_n(fl_n), .chain_in_n(xi_n), .input_mode_select(im),
    .output_mode_select(om), .parallel_in_bus(din), .serial_in_clock(sclk), .serial_in(sdat),
    .serial_in_expand(sexp), .input_width_tap(tap), .input_tap_en(tap_en), .parallel_out_bus(bus),
    .parallel_out_en(oen), .full_n(full_n), .empty_n(empty_n), .near_empty_full_n(near_n),
    .half_or_chain_out(half_n));
  function automatic logic [3:0] exp_flags(int c);
    return {c != D, c != 0, !(c < D / 8 || c > D - D / 8), !(c > D / 2)};
  endfunction
  task automatic flags_ok();
    #1;
    `CHK({full_n, empty_n, near_n, half_n}, exp_flags(cnt))
  endtask
  task automatic wr(input logic [WORD_W-1:0] w);
    @(posedge clk);
    din <= w;
    wr_n <= 0;
    repeat (4) @(posedge clk);
    wr_n <= 1;
    repeat (6) @(posedge clk);
    if (cnt < D && wr_ok) begin
      q.push_back(w);
      cnt++;
    end
    flags_ok();
  endtask
  task automatic rd(input logic oe);
    logic [WORD_W-1:0] e;
    @(posedge clk);
    oe_n <= oe;
    rd_n <= 0;
    repeat (5) @(posedge clk);
    #1;
    `CHK(oen, !oe && om)
    if (cnt > 0 && om) begin
      e = q.pop_front();
      cnt--;
      if (im) `CHK(bus, e)
      else `CHK(bus[7:0], e[7:0])
    end
    @(posedge clk);
    rd_n <= 1;
    oe_n <= 0;
    repeat (5) @(posedge clk);
    flags_ok();
    `CHK(oen, 1'b0)
  endtask
  task automatic do_rst(input logic i, input logic o);
    @(posedge clk);
    rst <= 1;
    im <= i;
    om <= o;
    repeat (16) @(posedge clk);
    rst <= 0;
    q.delete();
    cnt = 0;
    repeat (4) @(posedge clk);
  endtask
  // device reset pin pulse; first-load level is what the pulse captures
  task automatic pin_reset(input logic fl);
    @(posedge clk);
    fl_n <= fl;
    rs_n <= 0;
    repeat (6) @(posedge clk);
    rs_n <= 1;
    repeat (6) @(posedge clk);
    fl_n <= 1;
    q.delete();
    cnt = 0;
  endtask
  // one token handed in from the previous device of the chain
  task automatic xi_pulse();
    @(posedge clk);
    xi_n <= 0;
    repeat (4) @(posedge clk);
    xi_n <= 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    logic [WORD_W-1:0] w;
    void'($urandom(32'hA517));
    do_rst(1'b1, 1'b1);
    // one extra write past full and one read past empty are both refused
    for (int i = 0; i <= D; i++) begin
      w = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : WORD_W'($urandom);
      wr(w);
    end
    for (int i = 0; i <= D; i++) rd(i == 7);
    repeat (3) wr(WORD_W'($urandom));
    pin_reset(1'b1);
    flags_ok();
    rd(1'b0);
    foreach (keep[i]) begin
      keep[i] = WORD_W'($urandom);
      wr(keep[i]);
    end
    repeat (5) rd(1'b0);
    @(posedge clk);
    fl_n <= 0;
    repeat (6) @(posedge clk);
    fl_n <= 1;
    repeat (6) @(posedge clk);
    foreach (keep[i]) q.push_back(keep[i]);
    cnt = 5;
    flags_ok();
    repeat (5) rd(1'b0);
    do_rst(1'b0, 1'b1);
    #1;
    `CHK(tap_en, 1'b1)
    #3;
    for (int i = 0; i < 3; i++) begin
      keep[i] = {1'b0, 8'($urandom)};
      src.send(keep[i][7:0], 8);
    end
    src.send(8'h00, 1);
    for (int i = 0; i < 100 && empty_n !== 1'b1; i++) @(posedge clk);
    if (empty_n !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (10) @(posedge clk);
    for (int i = 0; i < 3; i++) q.push_back(keep[i]);
    cnt = 3;
    flags_ok();
    repeat (3) rd(1'b0);
    // depth chain: first device owns both tokens, any other waits for the chain
    do_rst(1'b1, 1'b1);
    @(posedge clk);
    xi_n <= 1;
    pin_reset(1'b0);
    wr(9'h0AA);
    rd(1'b0);
    pin_reset(1'b1);
    wr_ok = 0;
    wr(9'h155);
    wr_ok = 1;
    repeat (2) xi_pulse();
    wr(9'h133);
    rd(1'b0);
    // replay must not rewind the read pointer in a chain
    @(posedge clk);
    fl_n <= 0;
    repeat (6) @(posedge clk);
    fl_n <= 1;
    repeat (6) @(posedge clk);
    flags_ok();
    @(posedge clk);
    xi_n <= 0;
    do_rst(1'b1, 1'b0);
    wr(9'h155);
    rd(1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
